// ==== epirq_core_model.sv ====
`timescale 1ns/100ps

module epirq_core_model
    import epirq_pkg::*;
#(
    parameter int N = 7
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Vector entry
    input  wire logic         auto_ack,
    input  wire logic [N-1:0] req,
    output logic      [N-1:0] ack
);
    // A pulse stands for entry into the vector of each pending request.
    // Pulses are one cycle apart at best, as the flag needs that cycle to drop.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack <= '0;
        end else begin
            ack <= (auto_ack && ack == '0) ? req : '0;
        end
    end
endmodule : epirq_core_model

// ==== epirq_pkg.sv ====
package epirq_pkg;

    // Bus and block dimensions.
    localparam int ADDR_W   = 10;
    localparam int DATA_W   = 32;
    localparam int NUM_EXT  = 3;
    localparam int NUM_GRP  = 4;
    localparam int GRP_W    = 8;
    localparam int NUM_PC   = NUM_GRP * GRP_W;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_SENSE   = 8'h69;
    localparam logic [7:0] IDX_MASK0   = 8'h6B;
    localparam logic [7:0] IDX_MASK1   = 8'h6C;
    localparam logic [7:0] IDX_MASK2   = 8'h6D;
    localparam logic [7:0] IDX_MASK3   = 8'h73;
    localparam logic [7:0] IDX_EXT_EN  = 8'h3D;
    localparam logic [7:0] IDX_EXT_FLG = 8'h3C;
    localparam logic [7:0] IDX_PC_EN   = 8'h68;
    localparam logic [7:0] IDX_PC_FLG  = 8'h3B;

    // Values after reset.
    localparam logic [5:0] SENSE_RST  = 6'h00;
    localparam logic [7:0] MASK_RST   = 8'h00;
    localparam logic [2:0] EXT_EN_RST = 3'h0;
    localparam logic [2:0] EXT_FL_RST = 3'h0;
    localparam logic [3:0] PC_EN_RST  = 4'h0;
    localparam logic [3:0] PC_FL_RST  = 4'h0;

    // Cycles after reset before the synchroniser output is trusted.
    localparam logic [1:0] SYNC_FILL  = 2'h3;

    // Bus answers.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SENSE_LOW  = 2'b00,
        SENSE_ANY  = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } epirq_sense_t;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction : reg_addr

endpackage : epirq_pkg

// ==== epirq_sync.sv ====
`timescale 1ns/100ps

module epirq_sync
    import epirq_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Raw pins
    input  wire logic [W-1:0] pin_in,
    // Synchronised view
    output logic      [W-1:0] level_out,
    output logic      [W-1:0] change_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;
    logic [1:0]   fill_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Suppress the false edges that would otherwise follow reset while
    // the pipeline still holds its reset zeros.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fill_r <= 2'h0;
        end else if (fill_r != SYNC_FILL) begin
            fill_r <= fill_r + 2'h1;
        end
    end

    assign level_out  = sync_r;
    assign change_out = (fill_r == SYNC_FILL) ? (sync_r ^ prev_r) : '0;

endmodule : epirq_sync

// ==== epirq_top.sv ====
`timescale 1ns/100ps

// Contract
// - Pins trigger even when driven as outputs.
// - Any enabled toggle in group raises request.
// - Per-pin masks gate pin contribution.
// - Pin-change detection works without I/O clock; here it is sampled on aclk.
// - Sense select: low, any, falling, rising.
// - Level mode requests while pin low.
// - Level and edge detection asynchronous; here both pass two aclk flip-flops.
// - Vanished wake level gives no interrupt.
// - Sense register bits 7:6 read zero.
// - Line needs global flag and enable.
// - Flag sets on event, clears ack/write-one.
// - Level mode keeps flag cleared.
// - Sleep buffer gating may set flag.
// - Group enables need global flag too.
// - Groups 3,2 flags set on change.
// - Groups 1,0 flags behave the same.
// - Masks reset zero, need group enable.
module epirq_top
    import epirq_pkg::*;
(
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]   awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    // AXI4-Lite write data
    input  wire logic [DATA_W-1:0]   wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    // AXI4-Lite write response
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]   araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0]        rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    // External pins
    input  wire logic [NUM_EXT-1:0]  ext_irq_lines,
    input  wire logic [NUM_PC-1:0]   pin_change_inputs,
    // Core side
    input  wire logic                global_irq_enable,
    input  wire logic                sleep_active,
    input  wire logic [NUM_EXT-1:0]  ext_irq_ack,
    input  wire logic [NUM_GRP-1:0]  pc_group_ack,
    output logic [NUM_EXT-1:0]       ext_irq_request,
    output logic [NUM_GRP-1:0]       pc_group_request,
    output logic                     wake_request
);

    // Register state.
    logic [5:0]          sense_r;
    logic [7:0]          pc_mask_group0_r;
    logic [7:0]          pc_mask_group1_r;
    logic [7:0]          pc_mask_group2_r;
    logic [7:0]          pc_mask_group3_r;
    logic [NUM_EXT-1:0]  ext_irq_enable_r;
    logic [NUM_EXT-1:0]  ext_line_flag_r;
    logic [NUM_GRP-1:0]  pc_group_enable_r;
    logic [NUM_GRP-1:0]  pc_group_flag_r;

    // Bus state.
    logic                aw_held_r;
    logic [ADDR_W-1:0]   aw_addr_r;
    logic                w_held_r;
    logic [7:0]          w_data_r;
    logic                w_lane0_r;
    logic                bvalid_r;
    logic [1:0]          bresp_r;
    logic                rvalid_r;
    logic [1:0]          rresp_r;
    logic [DATA_W-1:0]   rdata_r;

    // Detection signals.
    logic [NUM_EXT-1:0]  ext_gated;
    logic [NUM_EXT-1:0]  ext_level;
    logic [NUM_EXT-1:0]  ext_change;
    logic [NUM_PC-1:0]   pc_change;
    logic [NUM_PC-1:0]   pc_mask_all;
    logic [NUM_PC-1:0]   pc_masked;
    logic [NUM_EXT-1:0]  ext_event;
    logic [NUM_EXT-1:0]  ext_is_level;
    logic [NUM_EXT-1:0]  ext_clear;
    logic [NUM_GRP-1:0]  pc_event;
    logic [NUM_GRP-1:0]  pc_clear;
    logic [NUM_EXT-1:0]  ext_pending;

    // Bus decode.
    logic                do_write;
    logic                wr_en;
    logic                wr_hit;
    logic [DATA_W-1:0]   rd_value;
    logic                rd_hit;

    // Decodes one line's sense select against its synchronised level.
    function automatic logic sense_event(input logic [1:0] sel,
                                         input logic       lvl,
                                         input logic       chg);
        logic ev;
        ev = 1'b0;
        case (epirq_sense_t'(sel))
            SENSE_LOW:  ev = 1'b0;
            SENSE_ANY:  ev = chg;
            SENSE_FALL: ev = chg & ~lvl;
            SENSE_RISE: ev = chg & lvl;
            default:    ev = 1'b0;
        endcase
        return ev;
    endfunction : sense_event

    function automatic logic [1:0] sel_of(input logic [5:0] s,
                                          input int         n);
        return s[2*n +: 2];
    endfunction : sel_of

    // Pins are read at the pad whatever their direction, so a pin driven
    // as an output still triggers.
    // A disabled line's input buffer is cut off in sleep, forcing a low
    // that the edge logic may see as a change.
    always_comb begin
        for (int n = 0; n < NUM_EXT; n++) begin
            ext_gated[n] = ext_irq_lines[n] &
                           ~(sleep_active & ~ext_irq_enable_r[n]);
        end
    end

    // The pins have no relation to aclk; each passes two flip-flops
    // before any flag or request logic looks at it.
    epirq_sync #(
        .W          (NUM_EXT)
    ) u_ext_sync (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pin_in     (ext_gated),
        .level_out  (ext_level),
        .change_out (ext_change)
    );

    epirq_sync #(
        .W          (NUM_PC)
    ) u_pc_sync (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pin_in     (pin_change_inputs),
        .level_out  (),
        .change_out (pc_change)
    );

    // Sense decode and flag clear terms.
    always_comb begin
        for (int n = 0; n < NUM_EXT; n++) begin
            ext_is_level[n] = (sel_of(sense_r, n) == SENSE_LOW);
            ext_event[n]    = sense_event(sel_of(sense_r, n),
                                          ext_level[n],
                                          ext_change[n]);
        end
    end

    assign pc_mask_all = {pc_mask_group3_r, pc_mask_group2_r,
                          pc_mask_group1_r, pc_mask_group0_r};
    assign pc_masked   = pc_change & pc_mask_all;

    always_comb begin
        for (int g = 0; g < NUM_GRP; g++) begin
            pc_event[g] = |pc_masked[g*GRP_W +: GRP_W];
        end
    end

    // Bus write path.
    assign awready  = ~aw_held_r & ~bvalid_r;
    assign wready   = ~w_held_r & ~bvalid_r;
    assign do_write = aw_held_r & w_held_r & ~bvalid_r;
    assign wr_en    = do_write & w_lane0_r;

    assign wr_hit = (aw_addr_r == reg_addr(IDX_SENSE))   ||
                    (aw_addr_r == reg_addr(IDX_MASK0))   ||
                    (aw_addr_r == reg_addr(IDX_MASK1))   ||
                    (aw_addr_r == reg_addr(IDX_MASK2))   ||
                    (aw_addr_r == reg_addr(IDX_MASK3))   ||
                    (aw_addr_r == reg_addr(IDX_EXT_EN))  ||
                    (aw_addr_r == reg_addr(IDX_EXT_FLG)) ||
                    (aw_addr_r == reg_addr(IDX_PC_EN))   ||
                    (aw_addr_r == reg_addr(IDX_PC_FLG));

    always_comb begin
        for (int n = 0; n < NUM_EXT; n++) begin
            ext_clear[n] = ext_irq_ack[n] |
                (wr_en & (aw_addr_r == reg_addr(IDX_EXT_FLG)) &
                 w_data_r[n]);
        end
        for (int g = 0; g < NUM_GRP; g++) begin
            pc_clear[g] = pc_group_ack[g] |
                (wr_en & (aw_addr_r == reg_addr(IDX_PC_FLG)) &
                 w_data_r[g]);
        end
    end

    // Address and data are taken in either order and held until both
    // are present; the write happens in the same cycle as bvalid rises.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (awvalid && awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= awaddr;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r  <= 1'b0;
            w_data_r  <= 8'h00;
            w_lane0_r <= 1'b0;
        end else if (wvalid && wready) begin
            w_held_r  <= 1'b1;
            w_data_r  <= wdata[7:0];
            w_lane0_r <= wstrb[0];
        end else if (do_write) begin
            w_held_r  <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Software registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sense_r           <= SENSE_RST;
            ext_irq_enable_r  <= EXT_EN_RST;
            pc_group_enable_r <= PC_EN_RST;
            pc_mask_group0_r  <= MASK_RST;
            pc_mask_group1_r  <= MASK_RST;
            pc_mask_group2_r  <= MASK_RST;
            pc_mask_group3_r  <= MASK_RST;
        end else if (wr_en) begin
            if (aw_addr_r == reg_addr(IDX_SENSE)) begin
                sense_r <= w_data_r[5:0];
            end else if (aw_addr_r == reg_addr(IDX_EXT_EN)) begin
                ext_irq_enable_r <= w_data_r[NUM_EXT-1:0];
            end else if (aw_addr_r == reg_addr(IDX_PC_EN)) begin
                pc_group_enable_r <= w_data_r[NUM_GRP-1:0];
            end else if (aw_addr_r == reg_addr(IDX_MASK0)) begin
                pc_mask_group0_r <= w_data_r;
            end else if (aw_addr_r == reg_addr(IDX_MASK1)) begin
                pc_mask_group1_r <= w_data_r;
            end else if (aw_addr_r == reg_addr(IDX_MASK2)) begin
                pc_mask_group2_r <= w_data_r;
            end else if (aw_addr_r == reg_addr(IDX_MASK3)) begin
                pc_mask_group3_r <= w_data_r;
            end
        end
    end

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_line_flag_r <= EXT_FL_RST;
        end else begin
            for (int n = 0; n < NUM_EXT; n++) begin
                if (ext_is_level[n]) begin
                    ext_line_flag_r[n] <= 1'b0;
                end else if (ext_event[n]) begin
                    ext_line_flag_r[n] <= 1'b1;
                end else if (ext_clear[n]) begin
                    ext_line_flag_r[n] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_group_flag_r <= PC_FL_RST;
        end else begin
            for (int g = 0; g < NUM_GRP; g++) begin
                if (pc_event[g]) begin
                    pc_group_flag_r[g] <= 1'b1;
                end else if (pc_clear[g]) begin
                    pc_group_flag_r[g] <= 1'b0;
                end
            end
        end
    end

    // Level mode asks only while the pin is still low, so a level that
    // leaves before the core is awake produces no interrupt.
    always_comb begin
        for (int n = 0; n < NUM_EXT; n++) begin
            ext_pending[n] = ext_is_level[n] ? ~ext_level[n]
                                             : ext_line_flag_r[n];
        end
    end

    assign ext_irq_request  = ext_pending & ext_irq_enable_r &
                              {NUM_EXT{global_irq_enable}};
    assign pc_group_request = pc_group_flag_r & pc_group_enable_r &
                              {NUM_GRP{global_irq_enable}};

    // Wake does not wait for the global flag; the core decides whether
    // to enter a handler once it runs again.
    assign wake_request = |(ext_pending & ext_irq_enable_r) |
                          |(pc_group_flag_r & pc_group_enable_r);

    // Bus read path.
    assign arready = ~rvalid_r;

    always_comb begin
        rd_hit   = 1'b1;
        rd_value = '0;
        if (araddr == reg_addr(IDX_SENSE)) begin
            rd_value[5:0] = sense_r;
        end else if (araddr == reg_addr(IDX_EXT_EN)) begin
            rd_value[NUM_EXT-1:0] = ext_irq_enable_r;
        end else if (araddr == reg_addr(IDX_EXT_FLG)) begin
            rd_value[NUM_EXT-1:0] = ext_line_flag_r;
        end else if (araddr == reg_addr(IDX_PC_EN)) begin
            rd_value[NUM_GRP-1:0] = pc_group_enable_r;
        end else if (araddr == reg_addr(IDX_PC_FLG)) begin
            rd_value[NUM_GRP-1:0] = pc_group_flag_r;
        end else if (araddr == reg_addr(IDX_MASK0)) begin
            rd_value[7:0] = pc_mask_group0_r;
        end else if (araddr == reg_addr(IDX_MASK1)) begin
            rd_value[7:0] = pc_mask_group1_r;
        end else if (araddr == reg_addr(IDX_MASK2)) begin
            rd_value[7:0] = pc_mask_group2_r;
        end else if (araddr == reg_addr(IDX_MASK3)) begin
            rd_value[7:0] = pc_mask_group3_r;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= '0;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_r  <= rd_value;
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign bvalid = bvalid_r;
    assign bresp  = bresp_r;
    assign rvalid = rvalid_r;
    assign rresp  = rresp_r;
    assign rdata  = rdata_r;

    // Checks.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_sense_rsvd;
        (arvalid && arready && araddr == reg_addr(IDX_SENSE))
            |=> (rvalid && rdata[7:6] == 2'b00);
    endproperty
    a_sense_rsvd: assert property (p_sense_rsvd)
        else $error("sense reserved bits read nonzero");

    property p_mask_reset;
        $rose(aresetn) |-> (pc_mask_all == '0);
    endproperty
    a_mask_reset: assert property (p_mask_reset)
        else $error("pin masks not zero after reset");

    generate
        for (genvar n = 0; n < NUM_EXT; n++) begin : g_ext_chk
            property p_ext_gate;
                ext_irq_request[n]
                    |-> (global_irq_enable && ext_irq_enable_r[n]);
            endproperty
            a_ext_gate: assert property (p_ext_gate)
                else $error("external request without enables");

            property p_level_req;
                (ext_is_level[n] && !ext_level[n] &&
                 ext_irq_enable_r[n] && global_irq_enable)
                    |-> ext_irq_request[n];
            endproperty
            a_level_req: assert property (p_level_req)
                else $error("level request missing while pin low");

            property p_level_flag;
                ext_is_level[n] |=> !ext_line_flag_r[n];
            endproperty
            a_level_flag: assert property (p_level_flag)
                else $error("flag set in level mode");

            property p_fall_set;
                (sel_of(sense_r, n) == SENSE_FALL && ext_change[n] &&
                 !ext_level[n]) ##1 (sel_of(sense_r, n) == SENSE_FALL)
                    |-> ext_line_flag_r[n];
            endproperty
            a_fall_set: assert property (p_fall_set)
                else $error("falling edge did not set flag");

            property p_rise_only;
                (sel_of(sense_r, n) == SENSE_RISE && !ext_line_flag_r[n]
                 && !(ext_change[n] && ext_level[n]))
                    |=> !ext_line_flag_r[n];
            endproperty
            a_rise_only: assert property (p_rise_only)
                else $error("flag set without a rising edge");

            property p_ext_w1c;
                (ext_line_flag_r[n] && ext_clear[n] && !ext_event[n])
                    |=> !ext_line_flag_r[n];
            endproperty
            a_ext_w1c: assert property (p_ext_w1c)
                else $error("external flag not cleared");
        end

        for (genvar g = 0; g < NUM_GRP; g++) begin : g_pc_chk
            property p_pc_set;
                pc_event[g] |=> pc_group_flag_r[g] [*1] ##0
                    ($past(pc_masked[g*GRP_W +: GRP_W]) != '0);
            endproperty
            a_pc_set: assert property (p_pc_set)
                else $error("group flag not set on masked change");

            property p_pc_mask;
                $rose(pc_group_flag_r[g])
                    |-> ($past(pc_change[g*GRP_W +: GRP_W] &
                               pc_mask_all[g*GRP_W +: GRP_W]) != '0);
            endproperty
            a_pc_mask: assert property (p_pc_mask)
                else $error("group flag set by masked-off pin");

            property p_pc_gate;
                pc_group_request[g] |-> (global_irq_enable &&
                    pc_group_enable_r[g] && pc_group_flag_r[g]);
            endproperty
            a_pc_gate: assert property (p_pc_gate)
                else $error("group request without enables");

            property p_pc_clear;
                (pc_group_ack[g] && !pc_event[g]) |=> !pc_group_flag_r[g];
            endproperty
            a_pc_clear: assert property (p_pc_clear)
                else $error("group flag not cleared by ack");
        end
    endgenerate

endmodule : epirq_top

// ==== testbench.sv ====
`timescale 1ns/100ps

module testbench
    import epirq_pkg::*;
;
    logic               aclk, aresetn, awvalid, wvalid, bready, arvalid;
    logic               rready, awready, wready, bvalid, arready, rvalid;
    logic               glob, auto_ack, sleep, wake;
    logic [ADDR_W-1:0]  awaddr, araddr;
    logic [DATA_W-1:0]  wdata, rdata;
    logic [1:0]         bresp, rresp, resp;
    logic [NUM_EXT-1:0] ext, ext_req;
    logic [NUM_GRP-1:0] pc_req;
    logic [6:0]         ack;
    logic [NUM_PC-1:0]  pins, npins;
    logic [7:0]         d, en, fl, c;
    logic [7:0]         msk [NUM_GRP];
    logic [7:0]         regs [9] = '{IDX_MASK0, IDX_MASK1, IDX_MASK2,
        IDX_MASK3, IDX_SENSE, IDX_EXT_EN, IDX_EXT_FLG, IDX_PC_EN, IDX_PC_FLG};
    int                 n_fail, samples_checked;

    epirq_top u_epirq_top (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ext_irq_lines(ext), .pin_change_inputs(pins),
        .global_irq_enable(glob), .sleep_active(sleep),
        .ext_irq_ack(ack[6:4]), .pc_group_ack(ack[3:0]),
        .ext_irq_request(ext_req), .pc_group_request(pc_req),
        .wake_request(wake));

    epirq_core_model u_epirq_core_model (
        .aclk(aclk), .aresetn(aresetn), .auto_ack(auto_ack),
        .req({ext_req, pc_req}), .ack(ack));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic check(input string nm, input logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    // Ready is looked at on the falling edge, where it is settled, and each
    // channel lets go only on the rising edge that took it.
    task automatic bus(input logic w, input logic [7:0] idx, v);
        logic a, b, r, done;
        if (w) begin
            awaddr <= {idx, 2'b00};
            wdata <= {24'h0, v};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= {idx, 2'b00};
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (int t = 0; t < 40; t++) begin
            @(negedge aclk);
            a = awvalid & awready;
            b = wvalid & wready;
            r = arvalid & arready;
            done = w ? bvalid : rvalid;
            resp = w ? bresp : rresp;
            d = rdata[7:0];
            @(posedge aclk);
            if (a) awvalid <= 1'b0;
            if (b) wvalid <= 1'b0;
            if (r) arvalid <= 1'b0;
            if (done) begin
                bready <= 1'b0;
                rready <= 1'b0;
                // Let an edge pass so a following call never re-raises
                // a ready in the same time step that lowered it.
                @(posedge aclk);
                return;
            end
        end
        n_fail++;
        wrap_up();
    endtask : bus

    task automatic exp_ext(input logic [7:0] f, input logic lvl);
        bus(1'b0, IDX_EXT_FLG, 8'h00);
        check("ext flags", d, f);
        @(negedge aclk);
        check("ext request", {5'h0, ext_req}, lvl ? 8'h07 : f);
        @(posedge aclk);
    endtask : exp_ext

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
        {wdata, glob, auto_ack, sleep, ext, pins} = '0;
        n_fail = 0;
        samples_checked = 0;
        aresetn = 1'b0;
        void'($urandom(32'ha898));
        tick(4);
        aresetn <= 1'b1;
        tick(4);
        foreach (regs[i]) begin
            bus(1'b0, regs[i], 8'h00);
            check("reset value", d, 8'h00);
        end
        bus(1'b1, IDX_SENSE, 8'hFF);
        bus(1'b0, IDX_SENSE, 8'h00);
        check("sense readback", d, 8'h3F);
        bus(1'b0, 8'h00, 8'h00);
        check("unmapped read", {resp, d[5:0]}, 8'h80);
        bus(1'b1, 8'h00, 8'h55);
        check("unmapped write", {6'h0, resp}, 8'h02);
        $display("registers test done");
        ext <= 3'h7;
        bus(1'b1, IDX_EXT_EN, 8'h07);
        glob <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, IDX_EXT_EN, 8'h00);
            bus(1'b1, IDX_SENSE, {2'b00, {3{m[1:0]}}});
            bus(1'b1, IDX_EXT_FLG, 8'h07);
            bus(1'b1, IDX_EXT_EN, 8'h07);
            ext <= 3'h0;
            tick(4);
            exp_ext((m == 1 || m == 2) ? 8'h07 : 8'h00, m == 0);
            ext <= 3'h7;
            tick(4);
            exp_ext((m == 0) ? 8'h00 : 8'h07, 1'b0);
        end
        $display("sense modes test done");
        // Sleeping with the lines disabled cuts their buffers, which the
        // any-edge mode must see as a change.
        bus(1'b1, IDX_EXT_EN, 8'h00);
        bus(1'b1, IDX_SENSE, 8'h15);
        bus(1'b1, IDX_EXT_FLG, 8'h07);
        glob <= 1'b0;
        sleep <= 1'b1;
        tick(4);
        bus(1'b0, IDX_EXT_FLG, 8'h00);
        check("sleep flags", d, 8'h07);
        sleep <= 1'b0;
        bus(1'b1, IDX_EXT_EN, 8'h07);
        @(negedge aclk);
        check("wake and request", {4'h0, wake, ext_req}, 8'h08);
        @(posedge aclk);
        $display("sleep test done");
        foreach (msk[g]) begin
            msk[g] = 8'($urandom);
            bus(1'b1, regs[g], msk[g]);
            bus(1'b0, regs[g], 8'h00);
            check("mask", d, msk[g]);
        end
        en = 8'($urandom) & 8'h0F;
        bus(1'b1, IDX_PC_EN, en);
        fl = 8'h00;
        for (int i = 0; i < 16; i++) begin
            npins = $urandom;
            for (int g = 0; g < 4; g++)
                if (|((npins[8*g+:8] ^ pins[8*g+:8]) & msk[g])) fl[g] = 1'b1;
            pins <= npins;
            glob <= 1'($urandom);
            tick(4);
            @(negedge aclk);
            check("pc request", {4'h0, pc_req}, fl & en & {8{glob}});
            @(posedge aclk);
            bus(1'b0, IDX_PC_FLG, 8'h00);
            check("pc flags", d, fl);
            c = 8'($urandom) & 8'h0F;
            bus(1'b1, IDX_PC_FLG, c);
            fl = fl & ~c;
        end
        $display("pin change test done");
        bus(1'b1, IDX_PC_EN, 8'h0F);
        bus(1'b1, IDX_MASK0, 8'hFF);
        glob <= 1'b1;
        auto_ack <= 1'b1;
        pins <= pins ^ 32'h0000_0001;
        tick(8);
        bus(1'b0, IDX_PC_FLG, 8'h00);
        check("pc flags after entry", d, 8'h00);
        bus(1'b0, IDX_EXT_FLG, 8'h00);
        check("ext flags after entry", d, 8'h00);
        $display("vector entry test done");
        wrap_up();
    end
endmodule : testbench
